/* File: acs_sequencer.sv */
// Conversion sequencer: start detect, clock divider, phase timing,
// busy and interrupt flags, and result byte placement.
// Assumes the analog core answers with a 12-bit code on the last
// conversion clock and that all inputs are synchronous to clk_i.
`timescale 1ns/1ps
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int SETTLE_CYC = ACS_SETTLE_CYC
)
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic start_i,                         // Start control bit
    input wire logic conv_power_enable_i,             // Power enable bit
    input wire logic [2:0] conv_clock_divider_select_i, // Divider select
    input wire logic result_align_select_i,           // Alignment bit
    input wire logic int_enable_i,                    // Interrupt enable
    input wire logic int_flag_clear_i,                // Clear request flag
    input wire logic [11:0] analog_code_i,            // Code from analog core
    output logic conv_busy_flag_o,                    // Busy flag
    output logic int_request_flag_o,                  // Sticky request flag
    output logic int_o,                               // Internal interrupt pulse
    output logic analog_power_o,                      // Analog core power
    output logic analog_sample_o,                     // Sample switch
    output logic conv_clock_o,                        // Conversion clock strobe
    output logic settled_o,                           // Settling elapsed
    output acs_result_s result_o                      // Result byte pair
);

    //------------------------------------------------------------------
    // Elaboration checks
    //------------------------------------------------------------------
    // The settling counter is sixteen bits wide
    if (SETTLE_CYC < 1 || SETTLE_CYC > 65535)
    begin : g_bad_settle
        $error("SETTLE_CYC out of range");
    end

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    // All state in one packed struct, registered as a whole
    typedef struct packed {
        logic start_q;          // Last start bit
        acs_phase_e phase;      // Sequence phase
        logic [6:0] prescale;   // System clock divider
        logic [4:0] tick_cnt;   // Conversion clocks in this conversion
        logic busy;             // Busy flag
        logic irq_flag;         // Request flag
        logic irq;              // Interrupt pulse
        logic power;            // Analog power
        logic sample;           // Sample switch
        logic ck;               // Conversion clock strobe
        logic [15:0] settle;    // Settling counter
        logic settled;          // Settling elapsed
        acs_result_s result;    // Result bytes
    } acs_state_s;

    acs_state_s state_r;
    acs_state_s state_nxt;

    // Decode helpers, filled by the next-state process
    logic launch;      // Falling edge of start
    logic div_tick;    // One conversion clock elapsed
    logic [6:0] div_mask; // Terminal prescale value

    //------------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------------
    // Timing of one conversion, in conversion clocks of 2^sel system clocks:
    //   launch edge   busy and sample switch rise, prescaler starts at zero
    //   ticks 1 to 4  sampling phase; the switch opens on the fourth tick
    //   ticks 5 to 16 conversion phase; the code is taken on the last tick
    //   tick 16       busy falls, request flag sets, interrupt pulses
    // Every tick also shows one cycle later as a pulse on conv_clock_o,
    // so the last pulse lands in the cycle where busy already reads 0.
    // A start edge seen while busy is dropped rather than queued, so
    // a polling routine never meets a conversion it did not ask for.
    // Power loss is checked after the phase decode so that it always wins.
    // Whole sequence; processor is never stalled, nothing waits on it
    always_comb
    begin
        state_nxt = state_r;
        launch = state_r.start_q && !start_i;
        div_mask = 7'((8'h01 << conv_clock_divider_select_i) - 8'h01);
        div_tick = (state_r.prescale == div_mask);
        state_nxt.start_q = start_i;
        state_nxt.irq = 1'b0;
        state_nxt.ck = 1'b0;
        state_nxt.power = conv_power_enable_i;
        // Settling counter restarts whenever power drops
        if (!conv_power_enable_i)
        begin
            state_nxt.settle = 16'h0000;
            state_nxt.settled = 1'b0;
        end
        else if (state_r.settle < 16'(SETTLE_CYC))
        begin
            state_nxt.settle = state_r.settle + 16'h0001;
        end
        else
        begin
            state_nxt.settled = 1'b1;
        end
        // Divider runs only during a conversion
        if (state_r.phase == ACS_IDLE || div_tick)
        begin
            state_nxt.prescale = ACS_DIV_RST;
        end
        else
        begin
            state_nxt.prescale = state_r.prescale + 7'h01;
        end
        case (state_r.phase)
            ACS_IDLE:
            begin
                // Launch only with power on
                if (launch && conv_power_enable_i)
                begin
                    state_nxt.phase = ACS_SAMPLE;
                    state_nxt.busy = 1'b1;
                    state_nxt.sample = 1'b1;
                    state_nxt.tick_cnt = 5'h00;
                end
            end
            ACS_SAMPLE:
            begin
                if (div_tick)
                begin
                    state_nxt.ck = 1'b1;
                    state_nxt.tick_cnt = state_r.tick_cnt + 5'h01;
                    if (state_r.tick_cnt == ACS_SAMPLE_CLKS - 5'h01)
                    begin
                        state_nxt.phase = ACS_CONVERT;
                        state_nxt.sample = 1'b0;
                    end
                end
            end
            ACS_CONVERT:
            begin
                if (div_tick)
                begin
                    state_nxt.ck = 1'b1;
                    state_nxt.tick_cnt = state_r.tick_cnt + 5'h01;
                    // Last of the twelve conversion clocks
                    if (state_r.tick_cnt == ACS_TOTAL_CLKS - 5'h01)
                    begin
                        state_nxt.phase = ACS_IDLE;
                        state_nxt.busy = 1'b0;
                        state_nxt.irq = int_enable_i;
                        if (result_align_select_i == ACS_ALIGN_LEFT)
                        begin
                            state_nxt.result.high_byte = analog_code_i[11:4];
                            state_nxt.result.low_byte = {4'h0, analog_code_i[3:0]};
                        end
                        else
                        begin
                            state_nxt.result.high_byte = {4'h0, analog_code_i[11:8]};
                            state_nxt.result.low_byte = analog_code_i[7:0];
                        end
                    end
                end
            end
            default:
            begin
                state_nxt.phase = ACS_IDLE;
            end
        endcase
        // Power loss aborts; result bytes are left as they were
        if (!conv_power_enable_i && state_r.phase != ACS_IDLE)
        begin
            state_nxt.phase = ACS_IDLE;
            state_nxt.busy = 1'b0;
            state_nxt.sample = 1'b0;
            state_nxt.irq = 1'b0;
            state_nxt.result = state_r.result;
        end
        // Request flag: set wins over clear
        // A clear in the completion cycle is lost; clear after completion
        if (state_r.phase == ACS_CONVERT && div_tick
            && state_r.tick_cnt == ACS_TOTAL_CLKS - 5'h01 && conv_power_enable_i)
        begin
            state_nxt.irq_flag = 1'b1;
        end
        else if (int_flag_clear_i)
        begin
            state_nxt.irq_flag = 1'b0;
        end
    end

    //------------------------------------------------------------------
    // State register
    //------------------------------------------------------------------
    // Synchronous reset to idle; every field clears, so the
    // start history reads low and a start bit that is low at
    // release cannot look like a falling edge
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_r <= '0;
            state_r.phase <= ACS_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    // Every output is a plain field of the state register, so no
    // output carries a combinational path from any input
    assign conv_busy_flag_o = state_r.busy;
    assign int_request_flag_o = state_r.irq_flag;
    assign int_o = state_r.irq;
    assign analog_power_o = state_r.power;
    assign analog_sample_o = state_r.sample;
    assign conv_clock_o = state_r.ck;
    assign settled_o = state_r.settled;
    assign result_o = state_r.result;

endmodule // acs_sequencer

/* File: acs_pkg.sv */
// Constants and carrier types for the conversion sequencer.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
//----------------------------------------------------------------------
// Overview of operation
// - Start bit high then low launches conversion
// - Busy flag rises once conversion launches
// - Busy flag clears when conversion ends
// - Interrupt request flag set per conversion
// - Enabled request raises internal interrupt
// - Divider select gives fsys over two-power
// - Analog power only while enable high
// - Sampling phase lasts four conversion clocks
// - Twelve conversion clocks follow, sixteen total
// - Conversion runs autonomously, never stalls
// - Result bytes follow alignment select
// - Results unchanged while converter disabled
//----------------------------------------------------------------------
package acs_pkg;
    // Phase lengths in conversion clocks
    localparam logic [4:0] ACS_SAMPLE_CLKS = 5'h04;
    localparam logic [4:0] ACS_CONV_CLKS = 5'h0c;
    localparam logic [4:0] ACS_TOTAL_CLKS = 5'h10;
    // Divider field width and prescale restart value
    localparam int ACS_DIV_W = 3;
    localparam logic [6:0] ACS_DIV_RST = 7'h00;
    // Settling wait, in ns, and its cycle count at 10 ns
    localparam int ACS_CLK_NS = 10;
    localparam int ACS_SETTLE_NS = 1000;
    localparam int ACS_SETTLE_CYC = (ACS_SETTLE_NS + ACS_CLK_NS - 1) / ACS_CLK_NS;
    // Alignment select encodings
    localparam logic ACS_ALIGN_LEFT = 1'b0;
    localparam logic ACS_ALIGN_RIGHT = 1'b1;

    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_SAMPLE,
        ACS_CONVERT
    } acs_phase_e;

    // Result byte pair
    typedef struct packed {
        logic [7:0] high_byte;
        logic [7:0] low_byte;
    } acs_result_s;
endpackage : acs_pkg

/* File: acs_sequencer_properties.sv */
// Timing checker for the conversion sequencer.
// Sees only the sequencer ports; one clock, synchronous reset.
`timescale 1ns/1ps
module acs_sequencer_properties
    import acs_pkg::*;
#(
    parameter int SETTLE_CYC = ACS_SETTLE_CYC
)
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire logic conv_power_enable_i,
    input wire logic [2:0] conv_clock_divider_select_i,
    input wire logic result_align_select_i,
    input wire logic int_enable_i,
    input wire logic int_flag_clear_i,
    input wire logic [11:0] analog_code_i,
    input wire logic conv_busy_flag_o,
    input wire logic int_request_flag_o,
    input wire logic int_o,
    input wire logic analog_power_o,
    input wire logic analog_sample_o,
    input wire logic conv_clock_o,
    input wire logic settled_o,
    input acs_result_s result_o
);
    logic [4:0] tick_cnt; // Ticks while busy
    logic [4:0] samp_cnt; // Ticks while sampling
    logic [7:0] gap; // Cycles since last tick
    logic [7:0] en_cnt; // Enable run length
    logic seen; // A tick seen in this conversion
    // Helper counters
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            {tick_cnt, samp_cnt, gap, en_cnt, seen} <= '0;
        else
        begin
            tick_cnt <= conv_busy_flag_o ? tick_cnt + 5'(conv_clock_o) : 5'h0;
            samp_cnt <= analog_sample_o ? samp_cnt + 5'(conv_clock_o) : 5'h0;
            gap <= conv_clock_o ? 8'h1 : gap + 8'h1;
            seen <= conv_busy_flag_o & (seen | conv_clock_o);
            en_cnt <= conv_power_enable_i ? en_cnt + 8'(en_cnt != 8'hff) : 8'h0;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_BUSY_RISE: assert property ($past(start_i) && !start_i && !conv_busy_flag_o
        && conv_power_enable_i && analog_power_o |=> conv_busy_flag_o) else $error("no busy");
    AST_TICK_GAP: assert property (conv_clock_o && seen && conv_busy_flag_o |->
        gap == (8'h1 << conv_clock_divider_select_i)) else $error("tick spacing");
    // Fourth sampling pulse shows up as the sample switch opens
    AST_SAMPLE: assert property ($fell(analog_sample_o) && conv_busy_flag_o |->
        conv_clock_o && samp_cnt == 5'd3) else $error("sample length");
    // Sixteenth pulse shows up in the cycle where busy already reads 0
    AST_TOTAL: assert property ($rose(int_request_flag_o) |->
        $fell(conv_busy_flag_o) && conv_clock_o && tick_cnt == 5'd15)
        else $error("total length");
    AST_INT_GATE: assert property (int_o |-> $past(int_enable_i)
        && $rose(int_request_flag_o)) else $error("stray interrupt");
    AST_INT_PULSE: assert property (int_o |=> !int_o) else $error("long pulse");
    AST_POWER: assert property (analog_power_o == $past(conv_power_enable_i))
        else $error("power lag");
    AST_ABORT: assert property (!conv_power_enable_i |-> ##2 !conv_busy_flag_o)
        else $error("busy unpowered");
    AST_RESULT: assert property ($changed(result_o) |-> $fell(conv_busy_flag_o))
        else $error("result moved");
    AST_SETTLE: assert property (settled_o |-> en_cnt >= SETTLE_CYC)
        else $error("early settle");
endmodule // acs_sequencer_properties
bind acs_sequencer acs_sequencer_properties #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.*);

/* File: acs_analog_model.sv */
// Analog core model: tracks the input while sampling, holds after.
// Unpowered it shows a toggling pattern instead of a stale code.
`timescale 1ns/1ps
module acs_analog_model
(
    input wire logic clk_i,
    input wire logic power_i,
    input wire logic sample_i,
    input wire logic [11:0] value_i,
    output logic [11:0] code_o
);
    logic [11:0] held_r = 12'h5a3; // Held code
    // Track, hold or scramble
    always @(posedge clk_i)
    begin
        if (!power_i)
            held_r <= ~held_r;
        else if (sample_i)
            held_r <= value_i;
    end
    assign code_o = held_r;
endmodule // acs_analog_model

/* File: acs_sequencer_tb.sv */
// Self-checking bench for the conversion sequencer.
// Drives at falling edges; a monitor scores each completion.
`timescale 1ns/1ps
module acs_sequencer_tb
    import acs_pkg::*;
;
    logic clk_i, sys_rst_i, start, pwr, align, ien, clr, settled, busy, flag, irq, apwr, samp;
    logic tick, flag_q;
    logic [2:0] sel;
    logic [11:0] val, code;
    logic [16:0] exp_v;
    acs_result_s res, last;
    logic [16:0] q[$]; // Expected {result, interrupt}
    int fail_count = 0, checks = 0, seed = 32'h6824;
    acs_sequencer #(.SETTLE_CYC(2)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start),
        .conv_power_enable_i(pwr), .conv_clock_divider_select_i(sel),
        .result_align_select_i(align), .int_enable_i(ien), .int_flag_clear_i(clr),
        .analog_code_i(code), .conv_busy_flag_o(busy), .int_request_flag_o(flag),
        .int_o(irq), .analog_power_o(apwr), .analog_sample_o(samp), .conv_clock_o(tick),
        .settled_o(settled), .result_o(res));
    acs_analog_model u_core (.clk_i(clk_i), .power_i(apwr), .sample_i(samp),
        .value_i(val), .code_o(code));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic launch();
        start = 1'b1;
        cyc(1);
        start = 1'b0;
    endtask
    // One conversion, with a stray start while busy
    task automatic conv(input logic [2:0] s, input logic a, input logic e);
        int n;
        sel = s;
        align = a;
        ien = e;
        val = 12'($random(seed));
        last = a ? {4'h0, val} : {val[11:4], 4'h0, val[3:0]};
        q.push_back({last, e});
        launch();
        cyc(2);
        chk(16'(busy), 16'h1);
        chk(16'(samp), 16'h1);
        launch();
        n = 0;
        while (busy === 1'b1 && n < 5000)
        begin
            cyc(1);
            n++;
        end
        chk(16'(n), 16'((32'd16 << s) - 32'd2));
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        chk(16'(flag), 16'h0);
    endtask
    // Score each rising request flag against the oldest note
    always @(negedge clk_i)
    begin
        if (flag === 1'b1 && flag_q !== 1'b1)
        begin
            exp_v = q.size() ? q.pop_front() : 17'h1ffff;
            chk(res, exp_v[16:1]);
            chk(16'(irq), 16'(exp_v[0]));
        end
        flag_q <= flag;
    end
    initial
    begin
        {start, pwr, align, ien, clr, sel, val} = '0;
        sys_rst_i = 1'b1;
        cyc(5);
        sys_rst_i = 1'b0;
        chk(res, 16'h0);
        launch();
        cyc(3);
        chk(16'(busy), 16'h0);
        pwr = 1'b1;
        cyc(5);
        chk(16'(settled), 16'h1);
        chk(16'(apwr), 16'h1);
        for (int i = 0; i < 8; i++)
            conv(3'(i), i[0], i[1]);
        sel = 3'h0;
        launch();
        cyc(12);
        pwr = 1'b0;
        cyc(3);
        chk(16'(busy), 16'h0);
        chk(res, last);
        pwr = 1'b1;
        cyc(5);
        conv(3'h6, 1'b1, 1'b1);
        pwr = 1'b0;
        cyc(2);
        chk(16'(apwr), 16'h0);
        chk(16'(q.size()), 16'h0);
        give_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        give_verdict();
    end
endmodule // acs_sequencer_tb
